//--- logic/tja_defines.svh
`ifndef TJA_DEFINES_SVH
`define TJA_DEFINES_SVH

// ****************************************
// fifo geometry
// ****************************************
`define TJA_DEPTH 7'd80
`define TJA_LAST 7'd79
`define TJA_HALF 7'd40
`define TJA_NEAR 7'd1
`define TJA_CALM_LO 7'd36
`define TJA_CALM_HI 7'd44

// ****************************************
// rates in hertz, nco words derived from them
// ****************************************
`define TJA_SYS_HZ 64'd125000000
`define TJA_T1_HZ 64'd1544000
`define TJA_E1_HZ 64'd2048000
`define TJA_T1_MIN_HZ 64'd1480000
`define TJA_T1_MAX_HZ 64'd1608000
`define TJA_E1_MIN_HZ 64'd1970000
`define TJA_E1_MAX_HZ 64'd2130000
`define TJA_WORD(hz) 32'(((hz) << 32) / `TJA_SYS_HZ)
// one ninety-sixth of a unit interval in accumulator units
`define TJA_UI_DIV 64'd96
`define TJA_STEP 32'((64'd1 << 32) / `TJA_UI_DIV)
`define TJA_FREQ_LSB 32'h0000_0400

// ****************************************
// loop gain: shift 6 gives the 5.7 Hz corner in t1, 5 gives 7.6 Hz in e1
// ****************************************
`define TJA_GAIN_T1 4'h6
`define TJA_GAIN_E1 4'h5
`define TJA_GAIN_MIN 4'h1
`define TJA_GAIN_MAX 4'hC
`define TJA_FREQ_SHIFT 4

`endif

//--- logic/tja_pkg.sv
`default_nettype none
package tja_pkg;
	// one line symbol as two nrz rails
	typedef struct packed
	{
		logic pos;
		logic neg;
	} tja_rail_s;

	// loop operating mode
	typedef enum logic [1:0]
	{
		TJA_ATTEN = 2'b01,
		TJA_TRACK = 2'b10
	} tja_mode_e;
endpackage
`default_nettype wire

//--- logic/tja_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// two flop synchroniser for levels
// ****************************************
module tja_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_ff; // metastable stage, read only by q_ff
	logic [W-1:0] q_ff;

	// both stages clear on reset
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_ff <= '0;
			q_ff <= '0;
		end
		else
		begin
			s1_ff <= d;
			q_ff <= s1_ff;
		end
	end

	assign q = q_ff;
endmodule
`default_nettype wire

//--- logic/tja_top.sv
// Contract
// RULE_01: dpll plus eighty entry elastic fifo
// RULE_02: both nrz rails pass through unchanged
// RULE_03: write on data clock, read smoothed
// RULE_04: t1/e1 clock, 1/96 ui phase steps
// RULE_05: long term frequency follows input average
// RULE_06: corner 5.7/7.6 Hz, 6 dB/octave
// RULE_07: programmable corner trim
// RULE_08: within one bit, track input directly
// RULE_09: tracking range limits per line mode
// RULE_10: upstream clock within 200/300 Hz
// RULE_11: absorb 80 ui peak-to-peak jitter
// RULE_12: reset pointers half apart, nominal rate
`timescale 1ns/1ps
`default_nettype none
`include "tja_defines.svh"
module tja_top (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic backplane_tx_clock,
	input wire logic recovered_receive_clock,
	input wire logic use_recovered_clock,
	input wire logic e1_mode,
	input wire logic [2:0] corner_trim,
	input wire tja_pkg::tja_rail_s tx_in,
	output logic smoothed_tx_line_clock,
	output tja_pkg::tja_rail_s tx_line,
	output logic tracking_mode,
	output logic [6:0] fifo_fill
);
	import tja_pkg::*;

	// ****************************************
	// write side, on the selected data clock
	// ****************************************
	// the select is a strap: changing it live can glitch the write clock
	logic wr_clk;
	assign wr_clk = use_recovered_clock ? recovered_receive_clock : backplane_tx_clock; // RULE_03

	logic [1:0] wr_rst_n_ff; // async assert, sync release
	logic [6:0] wr_ptr_ff;
	logic wr_tog_ff; // flips once per written symbol
	tja_rail_s mem [0:79]; // storage, cleared on reset so early reads are defined

	// reset release synchroniser for the write domain
	always_ff @(posedge wr_clk or posedge sys_rst)
	begin
		if (sys_rst)
			wr_rst_n_ff <= 2'h0;
		else
			wr_rst_n_ff <= {wr_rst_n_ff[0], 1'b1};
	end

	// write pointer starts half a fifo ahead of the read pointer
	always_ff @(posedge wr_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_ptr_ff <= `TJA_HALF; // RULE_12
			wr_tog_ff <= 1'b0;
		end
		else if (wr_rst_n_ff[1])
		begin
			wr_ptr_ff <= (wr_ptr_ff == `TJA_LAST) ? 7'h00 : wr_ptr_ff + 7'h01; // RULE_01
			wr_tog_ff <= ~wr_tog_ff;
		end
	end

	// both rails stored as they come, violations included
	// the first half fifo is read before any write lands, so it starts cleared
	always_ff @(posedge wr_clk or posedge sys_rst)
	begin
		if (sys_rst)
			mem <= '{default: '0};
		else if (wr_rst_n_ff[1])
			mem[wr_ptr_ff] <= tx_in; // RULE_02
	end

	// ****************************************
	// crossings into the system clock domain
	// ****************************************
	logic tog_s;
	logic [3:0] cfg_s;
	logic tog_d_ff;
	logic cfg_e1_d_ff;
	logic wr_evt;

	tja_sync #(.W(1)) u_tog_sync (.clk(mclk), .rst(sys_rst), .d(wr_tog_ff), .q(tog_s));
	tja_sync #(.W(4)) u_cfg_sync (.clk(mclk), .rst(sys_rst), .d({e1_mode, corner_trim}),
		.q(cfg_s));

	// edge of the synchronised toggle marks one written symbol
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tog_d_ff <= 1'b0;
			cfg_e1_d_ff <= 1'b0;
		end
		else
		begin
			tog_d_ff <= tog_s;
			cfg_e1_d_ff <= cfg_s[3];
		end
	end
	assign wr_evt = tog_s ^ tog_d_ff;

	// ****************************************
	// loop gain and limits from line mode
	// ****************************************
	// saturating clamp, used for gain and for the nco word
	function automatic logic [31:0] tja_clamp(input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		begin
			tja_clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
		end
	endfunction

	logic cfg_chg;
	logic [3:0] gain;
	logic [31:0] inc_nom;
	logic [31:0] inc_lo;
	logic [31:0] inc_hi;
	logic signed [15:0] thr; // proportional threshold
	logic signed [15:0] fthr; // integral threshold, sixteen times wider
	logic [31:0] gain_raw;

	assign cfg_chg = cfg_s[3] ^ cfg_e1_d_ff;
	// trim is signed and shifts the corner away from its default
	assign gain_raw = 32'(cfg_s[3] ? `TJA_GAIN_E1 : `TJA_GAIN_T1) + {{29{cfg_s[2]}}, cfg_s[2:0]};
	assign gain = 4'(tja_clamp(gain_raw, 32'(`TJA_GAIN_MIN), 32'(`TJA_GAIN_MAX))); // RULE_07
	assign thr = 16'sd1 <<< gain; // RULE_06
	assign fthr = thr <<< `TJA_FREQ_SHIFT;
	assign inc_nom = cfg_s[3] ? `TJA_WORD(`TJA_E1_HZ) : `TJA_WORD(`TJA_T1_HZ); // RULE_04
	assign inc_lo = cfg_s[3] ? `TJA_WORD(`TJA_E1_MIN_HZ) : `TJA_WORD(`TJA_T1_MIN_HZ); // RULE_09
	assign inc_hi = cfg_s[3] ? `TJA_WORD(`TJA_E1_MAX_HZ) : `TJA_WORD(`TJA_T1_MAX_HZ); // RULE_09

	// ****************************************
	// fill level, phase error and mode
	// ****************************************
	logic [6:0] fill_ff;
	logic [6:0] rd_ptr_ff;
	logic clk_ff;
	logic [31:0] acc_ff;
	logic clk_rise;
	logic do_rd;
	logic signed [7:0] err;
	tja_mode_e mode_ff;
	tja_mode_e nxt_mode;

	assign clk_rise = acc_ff[31] & ~clk_ff;
	// an empty fifo repeats the last symbol instead of wrapping
	assign do_rd = clk_rise && (fill_ff != 7'h00);
	assign err = $signed({1'b0, fill_ff}) - $signed({1'b0, `TJA_HALF});

	// symbols in flight: +1 per write, -1 per read
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			fill_ff <= `TJA_HALF; // RULE_12
		else
			fill_ff <= fill_ff + {6'h00, wr_evt} - {6'h00, do_rd}; // RULE_11
	end

	// near overflow or underflow gives up smoothing; hysteresis before return
	always_comb
	begin
		nxt_mode = mode_ff;
		case (mode_ff)
			TJA_ATTEN:
				if (fill_ff <= `TJA_NEAR || fill_ff >= `TJA_LAST - `TJA_NEAR + 7'h01 - 7'h01)
					nxt_mode = TJA_TRACK; // RULE_08
			TJA_TRACK:
				if (fill_ff >= `TJA_CALM_LO && fill_ff <= `TJA_CALM_HI)
					nxt_mode = TJA_ATTEN;
			default:
				nxt_mode = TJA_ATTEN;
		endcase
	end

	// mode register
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			mode_ff <= TJA_ATTEN;
		else
			mode_ff <= nxt_mode;
	end

	// ****************************************
	// phase detector, integrator and nco
	// ****************************************
	logic signed [15:0] ph_ff; // proportional path accumulator
	logic signed [15:0] fi_ff; // frequency path accumulator
	logic [31:0] inc_ff; // nco word
	logic adv;
	logic ret;
	logic signed [15:0] err16;

	assign err16 = 16'(err);
	// tracking steps once per output bit in the direction the fifo needs
	always_comb
	begin
		adv = 1'b0;
		ret = 1'b0;
		if (clk_rise)
		begin
			if (mode_ff == TJA_TRACK)
			begin
				adv = fill_ff > `TJA_HALF; // RULE_08
				ret = fill_ff < `TJA_HALF;
			end
			else
			begin
				adv = ph_ff >= thr;
				ret = ph_ff <= -thr;
			end
		end
	end

	// proportional path: one phase step each time the sum crosses thr
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			ph_ff <= 16'sh0000;
		else if (mode_ff == TJA_TRACK)
			ph_ff <= 16'sh0000;
		else if (clk_rise)
			ph_ff <= ph_ff + err16 - (adv ? thr : 16'sh0000) + (ret ? thr : 16'sh0000); // RULE_06
	end

	// integral path: the word drifts to the average input rate
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fi_ff <= 16'sh0000;
			inc_ff <= `TJA_WORD(`TJA_T1_HZ); // RULE_12
		end
		else if (cfg_chg)
		begin
			fi_ff <= 16'sh0000;
			inc_ff <= inc_nom; // RULE_12
		end
		else if (clk_rise)
		begin
			if (fi_ff + err16 >= fthr)
			begin
				fi_ff <= 16'sh0000;
				inc_ff <= tja_clamp(inc_ff + `TJA_FREQ_LSB, inc_lo, inc_hi); // RULE_05
			end
			else if (fi_ff + err16 <= -fthr)
			begin
				fi_ff <= 16'sh0000;
				inc_ff <= tja_clamp(inc_ff - `TJA_FREQ_LSB, inc_lo, inc_hi); // RULE_05
			end
			else
				fi_ff <= fi_ff + err16;
		end
	end

	// accumulator: msb is the line clock, a step moves it 1/96 ui
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			acc_ff <= 32'h0000_0000;
			clk_ff <= 1'b0;
		end
		else
		begin
			acc_ff <= acc_ff + inc_ff + (adv ? `TJA_STEP : 32'h0000_0000)
				- (ret ? `TJA_STEP : 32'h0000_0000); // RULE_04
			clk_ff <= acc_ff[31];
		end
	end

	// ****************************************
	// read side, paced by the smoothed clock
	// ****************************************
	tja_rail_s line_ff;

	// the entry read is at least one symbol from the writer, so it is settled
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			rd_ptr_ff <= 7'h00; // RULE_12
			line_ff <= '0;
		end
		else if (do_rd)
		begin
			rd_ptr_ff <= (rd_ptr_ff == `TJA_LAST) ? 7'h00 : rd_ptr_ff + 7'h01; // RULE_03
			line_ff <= mem[rd_ptr_ff]; // RULE_02
		end
	end

	assign smoothed_tx_line_clock = clk_ff;
	assign tx_line = line_ff;
	assign tracking_mode = (mode_ff == TJA_TRACK);
	assign fifo_fill = fill_ff;

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	logic seen_ff; // first cycle after reset release
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
			seen_ff <= 1'b0;
		else
			seen_ff <= 1'b1;
	end

	a_fill_bound: assert property (fill_ff <= `TJA_DEPTH) // RULE_01
		else $error("fifo fill above depth");
	a_rails_kept: assert property (do_rd |=> line_ff == $past(mem[rd_ptr_ff])) // RULE_02
		else $error("rails altered on read");
	a_read_paced: assert property ($changed(rd_ptr_ff) |-> $past(clk_rise)) // RULE_03
		else $error("read without clock rise");
	a_step_size: assert property (adv && !ret |=> acc_ff == $past(acc_ff) // RULE_04
		+ $past(inc_ff) + `TJA_STEP)
		else $error("phase step not 1/96 ui");
	a_word_range: assert property (!cfg_chg && !$past(cfg_chg) |-> inc_ff >= inc_lo // RULE_09
		&& inc_ff <= inc_hi)
		else $error("nco word outside tracking range");
	a_track_enter: assert property (mode_ff == TJA_ATTEN && fill_ff <= `TJA_NEAR // RULE_08
		|=> mode_ff == TJA_TRACK)
		else $error("no tracking near underflow");
	a_track_fast: assert property (mode_ff == TJA_TRACK && fill_ff > `TJA_HALF // RULE_08
		&& clk_rise |-> adv)
		else $error("tracking did not speed up");
	a_reset_half: assert property (!seen_ff |-> fill_ff == `TJA_HALF // RULE_12
		&& rd_ptr_ff == 7'h00)
		else $error("pointers not half apart after reset");
	// a nonzero trim must move the gain off its line mode default
	a_gain_trim: assert property (gain >= `TJA_GAIN_MIN && gain <= `TJA_GAIN_MAX // RULE_07
		&& (cfg_s[2:0] == 3'h0) == (gain == (cfg_s[3] ? `TJA_GAIN_E1 : `TJA_GAIN_T1)))
		else $error("loop gain not set by trim");
	a_freq_follow: assert property (clk_rise && !cfg_chg && (fi_ff + err16 >= fthr) // RULE_05
		&& inc_ff < inc_hi |=> inc_ff > $past(inc_ff))
		else $error("word did not follow input");

	c_enter_track: cover property (mode_ff == TJA_ATTEN ##1 mode_ff == TJA_TRACK);
	c_leave_track: cover property (mode_ff == TJA_TRACK ##1 mode_ff == TJA_ATTEN);
	c_step_adv: cover property (adv && mode_ff == TJA_ATTEN);
	c_step_ret: cover property (ret && mode_ff == TJA_ATTEN);
endmodule
`default_nettype wire

//--- dv/tja_framer_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// upstream framer: one short write clock pulse per symbol
// ****************************************
module tja_framer_model (
	input wire logic use_rcv,
	input wire logic run,
	input wire logic [19:0] gap_ps,
	output logic backplane_tx_clock,
	output logic recovered_receive_clock,
	output tja_pkg::tja_rail_s tx_in,
	output logic [15:0] n_sent
);
	import tja_pkg::*;

	logic bp_q = 1'h0; // backplane clock level
	logic rc_q = 1'h0; // recovered clock level
	tja_rail_s dat_q = '0; // symbol on the rails
	logic [15:0] cnt_q = 16'h0000; // symbols sent so far

	assign backplane_tx_clock = bp_q;
	assign recovered_receive_clock = rc_q;
	assign tx_in = dat_q;
	assign n_sent = cnt_q;

	// pattern repeats only after 128 symbols, so a lag search cannot alias
	function automatic tja_rail_s sym(input int k);
		return '{pos: k[0] ^ k[3] ^ k[5], neg: k[1] ^ k[4] ^ k[6] ^ k[0]};
	endfunction

	// clock rises 4.5 ns into a symbol, stays high for 7.5 ns and stands low between symbols
	always
	begin
		wait (run === 1'h1);
		dat_q = sym(cnt_q);
		#4.5;
		if (use_rcv)
			rc_q = 1'h1;
		else
			bp_q = 1'h1;
		#7.5;
		bp_q = 1'h0;
		rc_q = 1'h0;
		#3;
		// hold time is over: show the inverse so a late sample is caught
		dat_q = tja_rail_s'(~dat_q);
		cnt_q = cnt_q + 16'h0001;
		#(gap_ps / 1000.0 - 15.0);
	end
endmodule
`default_nettype wire

//--- dv/tja_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tja_top_tb;
	import tja_pkg::*;
	logic mclk = 1'h0;
	logic sys_rst = 1'h1;
	logic use_rcv = 1'h0;
	logic e1_mode = 1'h0;
	logic [2:0] corner_trim = 3'h0;
	logic run = 1'h1;
	logic [19:0] gap_ps = 20'h9E1F4;
	logic bp_clk, rc_clk, line_clk, trk;
	tja_rail_s tx_in, tx_line;
	logic [6:0] fill;
	logic [15:0] n_sent, k0;
	int n_fail = 0;
	int num_checks = 0;
	int cyc = 0;
	tja_rail_s out_q[$]; // line symbols taken on the falling line clock edge

	tja_top u_tja_top (.mclk(mclk), .sys_rst(sys_rst), .backplane_tx_clock(bp_clk),
		.recovered_receive_clock(rc_clk), .use_recovered_clock(use_rcv), .e1_mode(e1_mode),
		.corner_trim(corner_trim), .tx_in(tx_in), .smoothed_tx_line_clock(line_clk),
		.tx_line(tx_line), .tracking_mode(trk), .fifo_fill(fill));
	tja_framer_model u_tja_framer_model (.use_rcv(use_rcv), .run(run), .gap_ps(gap_ps),
		.backplane_tx_clock(bp_clk), .recovered_receive_clock(rc_clk), .tx_in(tx_in),
		.n_sent(n_sent));

	always #4 mclk = ~mclk;
	always @(posedge mclk) cyc <= cyc + 1;
	always @(negedge line_clk) out_q.push_back(tx_line);
	// hang guard, well above the roughly 45k cycles the run needs
	always @(posedge mclk)
	begin
		if (cyc == 90000)
		begin
			n_fail++;
			print_verdict();
		end
	end

	task automatic print_verdict;
		if (n_fail == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	function automatic tja_rail_s sym(input int k);
		return '{pos: k[0] ^ k[3] ^ k[5], neg: k[1] ^ k[4] ^ k[6] ^ k[0]};
	endfunction

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// range compare; an unknown value never passes
	task automatic check_rng(input string what, input int lo, input int hi, input logic [31:0] got);
		num_checks++;
		if ((got >= lo && got <= hi) !== 1'h1)
		begin
			n_fail++;
			$display("unexpected %s expected %0d..%0d seen %0d", what, lo, hi, got);
		end
	endtask

	// straps change only while reset is held; the write side leaves reset on its own clock
	task automatic do_reset(input logic e1, input logic rcv, input logic [2:0] trim,
		input logic [19:0] gap);
		@(posedge mclk) #1;
		sys_rst = 1'h1;
		e1_mode = e1;
		use_rcv = rcv;
		corner_trim = trim;
		gap_ps = gap;
		run = 1'h1;
		repeat (2) @(posedge mclk);
		#1;
		sys_rst = 1'h0;
		out_q = {};
		k0 = n_sent;
		check("fifo_fill", 32'h28, fill);
		check("tracking_mode", 32'h0, trk);
		check("line_clock", 32'h0, line_clk);
	endtask

	function automatic logic lag_ok(input int d);
		for (int r = 50; r < 66; r++)
			if (out_q[r] !== sym(k0 + r - d)) return 1'h0;
		return 1'h1;
	endfunction

	// line symbols from the fifty-first on must come out in order with both rails untouched
	task automatic check_stream(input int n);
		int hit;
		hit = -1;
		while (out_q.size() < n)
			@(posedge mclk);
		for (int d = 30; d <= 60 && hit < 0; d++)
		begin
			if (lag_ok(d))
				hit = d;
		end
		check("stream_lag_found", 32'h1, hit >= 0);
		if (hit >= 0)
		begin
			for (int r = 50; r < n; r++)
				check("tx_line", sym(k0 + r - hit), out_q[r]);
		end
	endtask

	task automatic meas(input int n, input int lo, input int hi, input string what);
		int t0;
		@(posedge line_clk);
		t0 = cyc;
		repeat (n) @(posedge line_clk);
		check_rng(what, lo, hi, cyc - t0);
	endtask

	task automatic wait_trk(input logic v);
		for (int i = 0; i < 20000 && trk !== v; i++) @(posedge mclk) #1;
		check("tracking_mode", v, trk);
	endtask

	// t1 on the backplane clock: data intact, rate equal to input average
	task automatic t_t1;
		do_reset(1'h0, 1'h0, 3'h0, 20'h9E1F4);
		check_stream(170);
		meas(32, 2583, 2599, "t1_period");
		check("tracking_mode", 32'h0, trk);
		check_rng("fifo_fill", 30, 50, fill);
	endtask

	// e1 on the recovered clock with a trimmed corner
	task automatic t_e1;
		do_reset(1'h1, 1'h1, 3'h2, 20'h77359);
		check_stream(170);
		meas(32, 1945, 1961, "e1_period");
	endtask

	// overrun then underrun drive the loop into tracking and back
	task automatic t_track;
		do_reset(1'h0, 1'h0, 3'h7, 20'h61A80);
		wait_trk(1'h1);
		check_rng("fill_near_full", 77, 80, fill);
		run = 1'h0;
		meas(16, 1240, 1400, "track_fast_period");
		wait_trk(1'h0);
		check_rng("fill_calm", 35, 45, fill);
		wait_trk(1'h1);
		check_rng("fill_near_empty", 0, 2, fill);
		meas(16, 1240, 1356, "track_slow_period");
	endtask

	initial
	begin
		t_t1();
		t_e1();
		t_track();
		print_verdict();
	end
endmodule
`default_nettype wire
